// ==== hw/ssd_diag_reg.sv ====
// Operation
// - Two 8-bit stages, shadow plus output.
// - Output pins three-state; disabled pins read back.
// - Shadow bit from previous, itself or pin.
// - Output bit from input bus or shadow.
// - Shadow changes only on diagnostic clock.
// - Mode low loads bus; high loads shadow.
// - Mode low: diagnostic edge shifts serial in.
// - Mode high, serial low: load from pins.
// - Mode high, serial high: shadow holds.
// - Mode low: serial out is top shadow bit.
// - Mode high: serial out follows serial in.
// - Both high: drive input bus next edge.
// - Driven input bus carries shadow bits.
// - Shifting never disturbs the output register.
// - Parts chain serially; controller allows ripple delay.
// - Mode low load may overlap shifting.
// - Mode high, serial low, pins enabled: simultaneous edges swap shadow and output.
`timescale 1ns/1ps
module ssd_diag_reg import ssd_pkg::*; #(
   parameter int W     = SSD_WIDTH,
   parameter int DEPTH = SSD_BUF_DEPTH
) (
   input  wire logic         core_clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         sys_load_clock_i,
   input  wire logic         diag_shift_clock_i,
   input  wire logic         scan_mode_i,
   input  wire logic         scan_serial_in_i,
   input  wire logic         out_enable_n_i,
   input  wire logic [W-1:0] parallel_in_bus_i,
   output logic      [W-1:0] parallel_in_bus_o,
   output logic              parallel_in_bus_oe_n_o,
   input  wire logic [W-1:0] registered_out_bus_i,
   output logic      [W-1:0] registered_out_bus_o,
   output logic              registered_out_bus_oe_n_o,
   output logic              scan_serial_out_o,
   output logic      [W-1:0] shadow_snap_data_o,
   output logic              shadow_snap_valid_o,
   input  wire logic         shadow_snap_ready_i
);
   localparam int SW = SSD_SYN_CTRL + 2 * W;

   logic [SW-1:0] sync_lvl;
   logic          sysclk_s;
   logic          diag_shift_clock_s;
   logic          mode_s;
   logic          sdi_s;
   logic          oen_s;
   logic [W-1:0]  pin_d_s;
   logic [W-1:0]  pin_b_s;

   ssd_pin_sync #(
      .W (SW)
   ) u_sync (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .pin_i      ({registered_out_bus_i, parallel_in_bus_i, out_enable_n_i,
                    scan_serial_in_i, scan_mode_i, diag_shift_clock_i, sys_load_clock_i}),
      .level_o    (sync_lvl)
   );

   assign sysclk_s = sync_lvl[SSD_SYN_SYSCLK];
   assign diag_shift_clock_s   = sync_lvl[SSD_SYN_DIAG_SHIFT_CLOCK];
   assign mode_s   = sync_lvl[SSD_SYN_MODE];
   assign sdi_s    = sync_lvl[SSD_SYN_SDI];
   assign oen_s    = sync_lvl[SSD_SYN_OEN];
   assign pin_d_s  = sync_lvl[SSD_SYN_CTRL +: W];
   assign pin_b_s  = sync_lvl[SSD_SYN_CTRL + W +: W];

   // Edge detection on the filtered clock levels.
   logic sysclk_d_r;
   logic diag_shift_clock_d_r;
   logic sys_rise;
   logic diag_shift_clock_rise;

   assign sys_rise  = sysclk_s && !sysclk_d_r;
   assign diag_shift_clock_rise = diag_shift_clock_s && !diag_shift_clock_d_r;

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         sysclk_d_r <= 1'b0;
         diag_shift_clock_d_r   <= 1'b0;
      end else begin
         sysclk_d_r <= sysclk_s;
         diag_shift_clock_d_r   <= diag_shift_clock_s;
      end
   end

   // Snapshot stream: every committed shadow value is offered to the reader.
   ssd_strm_if #(.W(W)) push_if ();
   ssd_strm_if #(.W(W)) pop_if ();

   ssd_snap_buf #(
      .W     (W),
      .DEPTH (DEPTH)
   ) u_buf (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .in_s       (push_if.snk),
      .out_s      (pop_if.src)
   );

   // Shadow stage. A diagnostic edge first becomes a pending word; it is
   // committed once the buffer accepts it, so a stalled reader loses nothing
   // as long as no more than DEPTH plus one diagnostic edges fall in the stall.
   ssd_shd_op_e  op;
   logic [W-1:0] shadow_r;
   logic [W-1:0] shadow_nxt;
   logic [W-1:0] pend_word_r;
   logic [W-1:0] pend_word_nxt;
   logic         pend_wb_r;
   logic         pend_wb_nxt;
   logic         pend_r;
   logic         pend_nxt;
   logic         wb_oe_n_r;
   logic         wb_oe_n_nxt;
   logic [W-1:0] base;
   logic         commit;

   assign commit = pend_r && push_if.ready;
   // A new edge chains onto an uncommitted word so consecutive shifts stay ordered.
   assign base   = pend_r ? pend_word_r : shadow_r;

   always_comb begin
      if (!mode_s) begin
         op = SSD_SHD_SHIFT;
      end else if (!sdi_s) begin
         op = SSD_SHD_LOAD;
      end else begin
         op = SSD_SHD_HOLD;
      end
   end

   always_comb begin
      shadow_nxt    = shadow_r;
      pend_word_nxt = pend_word_r;
      pend_wb_nxt   = pend_wb_r;
      pend_nxt      = pend_r;
      wb_oe_n_nxt   = wb_oe_n_r;
      if (commit) begin
         shadow_nxt   = pend_word_r;
         wb_oe_n_nxt  = !pend_wb_r;
         pend_nxt     = 1'b0;
      end
      if (diag_shift_clock_rise) begin
         unique case (op)
            SSD_SHD_SHIFT: pend_word_nxt = {base[W-2:0], sdi_s};
            SSD_SHD_LOAD:  pend_word_nxt = pin_b_s;
            SSD_SHD_HOLD:  pend_word_nxt = base;
         endcase
         pend_wb_nxt = mode_s && sdi_s;
         pend_nxt    = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         shadow_r    <= SSD_SHADOW_RST;
         pend_word_r <= SSD_SHADOW_RST;
         pend_wb_r   <= 1'b0;
         pend_r      <= 1'b0;
         wb_oe_n_r   <= 1'b1;
      end else begin
         shadow_r    <= shadow_nxt;
         pend_word_r <= pend_word_nxt;
         pend_wb_r   <= pend_wb_nxt;
         pend_r      <= pend_nxt;
         wb_oe_n_r   <= wb_oe_n_nxt;
      end
   end

   assign push_if.valid = commit;
   assign push_if.data  = pend_word_r;
   assign pop_if.ready  = shadow_snap_ready_i;

   // Output stage: touched only by system clock edges, never by shifting.
   logic [W-1:0] out_r;
   logic [W-1:0] out_nxt;
   logic         out_oen_r;
   logic         sso_r;
   logic         sso_nxt;

   always_comb begin
      out_nxt = out_r;
      if (sys_rise) begin
         out_nxt = mode_s ? shadow_r : pin_d_s;
      end
      sso_nxt = mode_s ? sdi_s : shadow_r[W-1];
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         out_r     <= SSD_OUT_RST;
         out_oen_r <= 1'b1;
         sso_r     <= 1'b0;
      end else begin
         out_r     <= out_nxt;
         out_oen_r <= oen_s;
         sso_r     <= sso_nxt;
      end
   end

   assign registered_out_bus_o      = out_r;
   assign registered_out_bus_oe_n_o = out_oen_r;
   assign parallel_in_bus_o         = shadow_r;
   // The write-back enable is stored active low so the pin enable leaves a flop directly.
   assign parallel_in_bus_oe_n_o    = wb_oe_n_r;
   assign scan_serial_out_o         = sso_r;
   assign shadow_snap_data_o        = pop_if.data;
   assign shadow_snap_valid_o       = pop_if.valid;

   // Checks.
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   property p_shift;
      diag_shift_clock_rise && !mode_s && !pend_r |=> pend_r && pend_word_r == {$past(shadow_r[W-2:0]), $past(sdi_s)};
   endproperty
   a_shift: assert property (p_shift) else $error("shift word wrong");

   property p_pin_load;
      diag_shift_clock_rise && mode_s && !sdi_s && !pend_r |=> pend_word_r == $past(pin_b_s);
   endproperty
   a_pin_load: assert property (p_pin_load) else $error("pin load word wrong");

   property p_hold;
      diag_shift_clock_rise && mode_s && sdi_s && !pend_r |=> pend_word_r == $past(shadow_r);
   endproperty
   a_hold: assert property (p_hold) else $error("hold word wrong");

   property p_commit;
      pend_r && push_if.ready && !diag_shift_clock_rise |=> shadow_r == $past(pend_word_r) && !pend_r;
   endproperty
   a_commit: assert property (p_commit) else $error("pending word not committed");

   property p_shadow_quiet;
      !(pend_r && push_if.ready) |=> $stable(shadow_r);
   endproperty
   a_shadow_quiet: assert property (p_shadow_quiet) else $error("shadow moved without diag edge");

   property p_out_quiet;
      !sys_rise |=> $stable(registered_out_bus_o);
   endproperty
   a_out_quiet: assert property (p_out_quiet) else $error("output register moved without sys edge");

   property p_out_from_shadow;
      sys_rise && mode_s |=> registered_out_bus_o == $past(shadow_r);
   endproperty
   a_out_from_shadow: assert property (p_out_from_shadow) else $error("mode high load wrong");

   property p_out_from_bus;
      sys_rise && !mode_s |=> registered_out_bus_o == $past(pin_d_s);
   endproperty
   a_out_from_bus: assert property (p_out_from_bus) else $error("mode low load wrong");

   property p_swap;
      sys_rise && diag_shift_clock_rise && mode_s && !sdi_s && !pend_r
         |=> registered_out_bus_o == $past(shadow_r) && pend_word_r == $past(pin_b_s);
   endproperty
   a_swap: assert property (p_swap) else $error("swap failed");

   property p_sdo_shift;
      !mode_s |=> scan_serial_out_o == $past(shadow_r[W-1]);
   endproperty
   a_sdo_shift: assert property (p_sdo_shift) else $error("serial out not top bit");

   property p_sdo_pass;
      mode_s |=> scan_serial_out_o == $past(sdi_s);
   endproperty
   a_sdo_pass: assert property (p_sdo_pass) else $error("serial out not passing control");

   property p_wb_on;
      diag_shift_clock_rise && mode_s && sdi_s && !pend_r && push_if.ready ##1 push_if.ready
         |=> !parallel_in_bus_oe_n_o;
   endproperty
   a_wb_on: assert property (p_wb_on) else $error("write-back drive not enabled");

   property p_wb_off;
      diag_shift_clock_rise && !(mode_s && sdi_s) && !pend_r ##1 push_if.ready |=> parallel_in_bus_oe_n_o;
   endproperty
   a_wb_off: assert property (p_wb_off) else $error("write-back drive not released");

   property p_wb_data;
      !parallel_in_bus_oe_n_o && !commit |=> parallel_in_bus_o == $past(parallel_in_bus_o);
   endproperty
   a_wb_data: assert property (p_wb_data) else $error("write-back data moved");

   property p_oen_follow;
      1'b1 |=> registered_out_bus_oe_n_o == $past(oen_s);
   endproperty
   a_oen_follow: assert property (p_oen_follow) else $error("output enable not followed");

   property p_wb_stable;
      !commit |=> $stable(parallel_in_bus_oe_n_o);
   endproperty
   a_wb_stable: assert property (p_wb_stable) else $error("write-back drive moved");

   property p_stall_keeps;
      pend_r && !push_if.ready |=> pend_r && $stable(shadow_r);
   endproperty
   a_stall_keeps: assert property (p_stall_keeps) else $error("stalled word lost");

   c_shift: cover property (diag_shift_clock_rise && !mode_s);
   c_swap: cover property (sys_rise && diag_shift_clock_rise && mode_s && !sdi_s);
   c_wb: cover property ($fell(parallel_in_bus_oe_n_o));
   c_stall: cover property (pend_r && !push_if.ready);
   c_pin_load: cover property (diag_shift_clock_rise && mode_s && !sdi_s && !sys_rise);
endmodule : ssd_diag_reg

// ==== hw/ssd_pkg.sv ====
package ssd_pkg;

   // Width of the data path, the shadow register and both pin buses.
   localparam int SSD_WIDTH = 8;

   // Depth of the snapshot buffer between the shadow register and its reader.
   localparam int SSD_BUF_DEPTH = 2;

   // Bit positions of the control pins inside the synchroniser vector.
   localparam int SSD_SYN_SYSCLK = 0;
   localparam int SSD_SYN_DIAG_SHIFT_CLOCK   = 1;
   localparam int SSD_SYN_MODE   = 2;
   localparam int SSD_SYN_SDI    = 3;
   localparam int SSD_SYN_OEN    = 4;
   localparam int SSD_SYN_CTRL   = 5;

   // Reset values of the register stages.
   localparam logic [SSD_WIDTH-1:0] SSD_SHADOW_RST = 8'h00;
   localparam logic [SSD_WIDTH-1:0] SSD_OUT_RST    = 8'h00;

   // Source selected for the next shadow value on a diagnostic clock edge.
   typedef enum logic [1:0] {
      SSD_SHD_SHIFT,
      SSD_SHD_LOAD,
      SSD_SHD_HOLD
   } ssd_shd_op_e;

endpackage : ssd_pkg

// ==== hw/ssd_strm_if.sv ====
`timescale 1ns/1ps
interface ssd_strm_if #(
   parameter int W = 8
);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : ssd_strm_if

// ==== hw/ssd_pin_sync.sv ====
`timescale 1ns/1ps
module ssd_pin_sync import ssd_pkg::*; #(
   parameter int W = 8
) (
   input  wire logic         core_clk_i,
   input  wire logic         rst_n_i,
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] level_o
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] lvl_r;
   logic [W-1:0] lvl_nxt;

   // A bit only moves once the second and third stages agree, which filters
   // a single sample caught mid-transition.
   always_comb begin
      for (int i = 0; i < W; i++) begin
         lvl_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : lvl_r[i];
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         s1_r  <= '0;
         s2_r  <= '0;
         s3_r  <= '0;
         lvl_r <= '0;
      end else begin
         s1_r  <= pin_i;
         s2_r  <= s1_r;
         s3_r  <= s2_r;
         lvl_r <= lvl_nxt;
      end
   end

   assign level_o = lvl_r;
endmodule : ssd_pin_sync

// ==== hw/ssd_snap_buf.sv ====
`timescale 1ns/1ps
module ssd_snap_buf import ssd_pkg::*; #(
   parameter int W     = SSD_WIDTH,
   parameter int DEPTH = SSD_BUF_DEPTH
) (
   input  wire logic   core_clk_i,
   input  wire logic   rst_n_i,
   ssd_strm_if.snk     in_s,
   ssd_strm_if.src     out_s
);
   logic [W-1:0]     mem_r   [DEPTH];
   logic [W-1:0]     mem_nxt [DEPTH];
   logic [DEPTH-1:0] v_r;
   logic [DEPTH-1:0] v_nxt;
   logic             pop;
   logic             push;
   logic             placed;

   // Entry 0 is always the head, so the reader sees flip-flops directly.
   assign pop  = v_r[0] && out_s.ready;
   assign push = in_s.valid && in_s.ready;

   always_comb begin
      placed = 1'b0;
      mem_nxt = mem_r;
      v_nxt   = v_r;
      if (pop) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            mem_nxt[i] = mem_r[i+1];
            v_nxt[i]   = v_r[i+1];
         end
         v_nxt[DEPTH-1] = 1'b0;
      end
      if (push) begin
         for (int i = 0; i < DEPTH; i++) begin
            if (!v_nxt[i] && !placed) begin
               mem_nxt[i] = in_s.data;
               v_nxt[i]   = 1'b1;
               placed     = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         v_r <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            mem_r[i] <= '0;
         end
      end else begin
         v_r   <= v_nxt;
         mem_r <= mem_nxt;
      end
   end

   // Full is judged without the same-cycle pop, trading one slot of
   // throughput for a ready that does not depend on the reader.
   assign in_s.ready  = !v_r[DEPTH-1];
   assign out_s.valid = v_r[0];
   assign out_s.data  = mem_r[0];
endmodule : ssd_snap_buf

// ==== tb/ssd_ctrl_model.sv ====
`timescale 1ns/1ps
module ssd_ctrl_model (
   input  wire logic core_clk_i,
   output logic      sys_load_clock_o,
   output logic      diag_shift_clock_o,
   output logic      scan_mode_o,
   output logic      scan_serial_in_o
);
   initial begin
      sys_load_clock_o   = 1'b0;
      diag_shift_clock_o = 1'b0;
      scan_mode_o        = 1'b0;
      scan_serial_in_o   = 1'b0;
   end

   // Both clocks stay low between frames, so only commanded edges are ever seen.
   task automatic step(input logic m, input logic s, input logic do_sys, input logic do_diag);
      @(negedge core_clk_i);
      // Control settles a full cycle ahead of the clocks to cover ripple along a chain.
      scan_mode_o      = m;
      scan_serial_in_o = s;
      @(negedge core_clk_i);
      sys_load_clock_o   = do_sys;
      diag_shift_clock_o = do_diag;
      // Forty nanoseconds high, then forty low before the frame ends; back-to-back frames give a 100 ns clock period.
      repeat (4) @(negedge core_clk_i);
      sys_load_clock_o   = 1'b0;
      diag_shift_clock_o = 1'b0;
      repeat (4) @(negedge core_clk_i);
   endtask : step
endmodule : ssd_ctrl_model

// ==== tb/ssd_diag_reg_test.sv ====
`timescale 1ns/1ps
module ssd_diag_reg_test import ssd_pkg::*;;
   logic                 core_clk;
   logic                 rst_n;
   logic                 sys_clk;
   logic                 diag_shift_clock;
   logic                 mode;
   logic                 scan_serial_in;
   logic                 out_en_n;
   logic                 snap_ready;
   logic [SSD_WIDTH-1:0] par_drv;
   logic [SSD_WIDTH-1:0] out_drv;
   logic [SSD_WIDTH-1:0] par_o;
   logic [SSD_WIDTH-1:0] out_o;
   logic [SSD_WIDTH-1:0] snap_data;
   logic                 par_oe_n;
   logic                 out_oe_n;
   logic                 scan_serial_out;
   logic                 snap_valid;
   wire  [SSD_WIDTH-1:0] par_wire;
   wire  [SSD_WIDTH-1:0] out_wire;
   logic [7:0]           exp_sh;
   logic [7:0]           exp_out;
   logic [7:0]           snaps[$];
   int                   num_errors;
   int                   comparisons;

   // Each bus shows the device's value while it drives, otherwise what the bench drives.
   assign out_wire = (out_oe_n === 1'b0) ? out_o : out_drv;
   assign par_wire = (par_oe_n === 1'b0) ? par_o : par_drv;

   ssd_ctrl_model ctrl (
      .core_clk_i         (core_clk),
      .sys_load_clock_o   (sys_clk),
      .diag_shift_clock_o (diag_shift_clock),
      .scan_mode_o        (mode),
      .scan_serial_in_o   (scan_serial_in)
   );

   ssd_diag_reg uut (
      .core_clk_i                (core_clk),
      .rst_n_i                   (rst_n),
      .sys_load_clock_i          (sys_clk),
      .diag_shift_clock_i        (diag_shift_clock),
      .scan_mode_i               (mode),
      .scan_serial_in_i          (scan_serial_in),
      .out_enable_n_i            (out_en_n),
      .parallel_in_bus_i         (par_wire),
      .parallel_in_bus_o         (par_o),
      .parallel_in_bus_oe_n_o    (par_oe_n),
      .registered_out_bus_i      (out_wire),
      .registered_out_bus_o      (out_o),
      .registered_out_bus_oe_n_o (out_oe_n),
      .scan_serial_out_o         (scan_serial_out),
      .shadow_snap_data_o        (snap_data),
      .shadow_snap_valid_o       (snap_valid),
      .shadow_snap_ready_i       (snap_ready)
   );

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      if (rst_n === 1'b1 && snap_valid === 1'b1 && snap_ready === 1'b1) begin
         snaps.push_back(snap_data);
      end
   end

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic snap(input logic [7:0] exp);
      repeat (20) if (snaps.size() == 0) @(negedge core_clk);
      chk("snapshot present", {7'h00, snaps.size() != 0}, 8'h01);
      if (snaps.size() != 0) chk("snapshot", snaps.pop_front(), exp);
   endtask : snap

   task automatic close_out;
      if (num_errors == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : close_out

   task automatic t_reset;
      chk("out bus", out_o, SSD_OUT_RST);
      chk("in bus oe_n", {7'h00, par_oe_n}, 8'h01);
      chk("snap valid", {7'h00, snap_valid}, 8'h00);
      chk("out bus oe_n", {7'h00, out_oe_n}, 8'h00);
   endtask : t_reset

   task automatic t_shift;
      logic [7:0] pat;
      pat = 8'hA5;
      for (int i = 7; i >= 0; i--) begin
         ctrl.step(1'b0, pat[i], 1'b0, 1'b1);
         exp_sh = {exp_sh[6:0], pat[i]};
         snap(exp_sh);
         chk("serial out", {7'h00, scan_serial_out}, {7'h00, exp_sh[7]});
         chk("out bus", out_o, exp_out);
      end
   endtask : t_shift

   task automatic t_load_while_shift;
      par_drv = 8'h3C;
      ctrl.step(1'b0, 1'b1, 1'b1, 1'b1);
      exp_out = 8'h3C;
      exp_sh  = {exp_sh[6:0], 1'b1};
      chk("out bus", out_o, exp_out);
      snap(exp_sh);
   endtask : t_load_while_shift

   task automatic t_out_from_shadow;
      ctrl.step(1'b1, 1'b1, 1'b1, 1'b0);
      exp_out = exp_sh;
      chk("out bus", out_o, exp_out);
      chk("serial out", {7'h00, scan_serial_out}, 8'h01);
      chk("in bus oe_n", {7'h00, par_oe_n}, 8'h01);
   endtask : t_out_from_shadow

   task automatic t_pin_load;
      out_en_n = 1'b1;
      out_drv  = 8'h96;
      // The enable and then the released pin level must both cross the synchroniser first.
      repeat (8) @(negedge core_clk);
      ctrl.step(1'b1, 1'b0, 1'b0, 1'b1);
      exp_sh = 8'h96;
      snap(exp_sh);
      chk("serial out", {7'h00, scan_serial_out}, 8'h00);
      chk("out bus oe_n", {7'h00, out_oe_n}, 8'h01);
      chk("out bus", out_o, exp_out);
   endtask : t_pin_load

   task automatic t_write_back;
      par_drv = 8'h5A;
      ctrl.step(1'b1, 1'b1, 1'b0, 1'b1);
      snap(exp_sh);
      chk("in bus oe_n", {7'h00, par_oe_n}, 8'h00);
      chk("in bus data", par_wire, exp_sh);
      ctrl.step(1'b0, 1'b0, 1'b0, 1'b1);
      exp_sh = {exp_sh[6:0], 1'b0};
      snap(exp_sh);
      chk("in bus oe_n", {7'h00, par_oe_n}, 8'h01);
   endtask : t_write_back

   task automatic t_swap;
      logic [7:0] tmp;
      out_en_n = 1'b0;
      tmp      = exp_sh;
      repeat (8) @(negedge core_clk);
      ctrl.step(1'b1, 1'b0, 1'b1, 1'b1);
      exp_sh  = exp_out;
      exp_out = tmp;
      chk("out bus", out_o, exp_out);
      snap(exp_sh);
   endtask : t_swap

   task automatic t_buffer;
      logic [7:0] e[3];
      snap_ready = 1'b0;
      for (int i = 0; i < 3; i++) begin
         ctrl.step(1'b0, i[0], 1'b0, 1'b1);
         exp_sh = {exp_sh[6:0], i[0]};
         e[i]   = exp_sh;
         chk("snap valid", {7'h00, snap_valid}, 8'h01);
      end
      chk("taken while stalled", 8'(snaps.size()), 8'h00);
      snap_ready = 1'b1;
      for (int i = 0; i < 3; i++) snap(e[i]);
   endtask : t_buffer

   initial begin
      num_errors  = 0;
      comparisons = 0;
      rst_n       = 1'b0;
      out_en_n    = 1'b0;
      snap_ready  = 1'b1;
      par_drv     = 8'h00;
      out_drv     = 8'hFF;
      exp_sh      = SSD_SHADOW_RST;
      exp_out     = SSD_OUT_RST;
      repeat (2) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (6) @(negedge core_clk);
      t_reset();
      t_shift();
      t_load_while_shift();
      t_out_from_shadow();
      t_pin_load();
      t_write_back();
      t_swap();
      t_buffer();
      close_out();
   end

   // About twenty frames of under twenty cycles plus snapshot waits; this leaves a wide margin.
   initial begin
      #20us;
      num_errors++;
      close_out();
   end
endmodule : ssd_diag_reg_test
